// ### scb_pkg.sv
// constants, bus carriers and state codes for the system control register bank
`default_nettype none

package scb_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int SCB_AW = 6;
    localparam int SCB_DW = 32;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [SCB_AW-1:0] SCB_OFS_TABLE = 6'h08;
    localparam logic [SCB_AW-1:0] SCB_OFS_RESET_CTL = 6'h0C;
    localparam logic [SCB_AW-1:0] SCB_OFS_SLEEP = 6'h10;
    localparam logic [SCB_AW-1:0] SCB_OFS_CONFIG = 6'h14;
    localparam logic [SCB_AW-1:0] SCB_OFS_PRI2 = 6'h1C;
    localparam logic [SCB_AW-1:0] SCB_OFS_PRI3 = 6'h20;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SCB_TBL_LSB = 7;
    localparam int SCB_KEY_LSB = 16;
    localparam logic [15:0] SCB_WRITE_KEY = 16'h05FA;
    localparam int SCB_BYTE_ORDER_BIT = 15;
    localparam int SCB_RESET_REQ_BIT = 2;
    localparam int SCB_DBG_CLR_BIT = 1;
    localparam int SCB_EOP_BIT = 4;
    localparam int SCB_DEEP_BIT = 2;
    localparam int SCB_SOE_BIT = 1;
    localparam int SCB_STACK8_BIT = 9;
    localparam int SCB_TRAP_BIT = 3;
    localparam int SCB_PRI_SVC_MSB = 31;
    localparam int SCB_PRI_PSV_MSB = 23;
    localparam int SCB_PRI_TICK_MSB = 31;
    localparam logic [7:0] SCB_PRI_MAX = 8'hC0;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [24:0] SCB_TBL_RST = 25'h0000000;
    localparam logic [1:0] SCB_PRI_RST = 2'h0;
    localparam logic SCB_CTL_RST = 1'b0;

    // ------------------------------------------------------------
    // carriers and state codes
    // ------------------------------------------------------------
    typedef struct packed {
        logic read;
        logic write;
        logic [SCB_AW-1:0] address;
        logic [SCB_DW-1:0] writedata;
        logic [3:0] byteenable;
    } scb_bus_req_s;

    typedef struct packed {
        logic [SCB_DW-1:0] readdata;
        logic waitrequest;
    } scb_bus_rsp_s;

    typedef enum logic [1:0] {
        SCB_IDLE = 2'b01,
        SCB_ACK = 2'b10
    } scb_bus_e;

endpackage : scb_pkg

`default_nettype wire

// ### scb_regs.sv
// system control register bank with sleep, wake-up and reset request logic
//
// Register access over Avalon-MM and the address map are this design's own decisions.
`default_nettype none

// Functional notes
// - table offset stores bits 31:7 of vector table base; bits 6:0 not stored.
// - reset control write acts only with key 0x05FA in bits 31:16, else discarded.
// - key field reads give no meaningful value; software ignores it.
// - byte order bit 15 always reads zero, meaning little-endian.
// - keyed write of one to bit 2 requests system reset; bit reads zero.
// - debug clear-active bit 1 reads zero; software writes zero there.
// - event-on-pending zero: enabled interrupts wake; one: all interrupts wake.
// - new pending event wakes waiting core, else is latched for next wait.
// - send-event instruction or external event input also wakes the core.
// - deep sleep select picks ordinary sleep at zero, deep sleep at one.
// - sleep-on-return set makes handler return to thread enter sleep.
// - stack alignment flag bit 9 reads one, eight-byte alignment.
// - misaligned trap flag reads one; each unaligned access raises hard fault.
// - second priority register holds supervisor call priority in top byte.
// - third priority register holds pendable service priority in bits 23:16.
// - third priority register holds tick priority in top byte, low half zero.
// - priority fields store only bits 7:6; bits 5:0 read zero.
// - configurable priority levels run 0 to 192 in steps of 64.

module scb_regs
    import scb_pkg::*;
#(
    parameter int IRQ_N = 32
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire scb_bus_req_s bus_req,
    output var scb_bus_rsp_s bus_rsp,
    input wire logic [IRQ_N-1:0] irq_pending,
    input wire logic [IRQ_N-1:0] irq_enable,
    input wire logic send_event_instr,
    input wire logic ext_event,
    input wire logic core_in_wait_for_event,
    input wire logic handler_to_thread,
    input wire logic misaligned_access,
    output logic wake_core,
    output logic sleep_enter,
    output logic deep_sleep_select,
    output logic system_reset_request,
    output logic hard_fault_exception,
    output logic [24:0] table_base_field,
    output logic [1:0] supervisor_call_priority,
    output logic [1:0] pendable_service_priority,
    output logic [1:0] tick_priority
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        scb_bus_e bus_st;
        logic rsp_wait;
        logic [SCB_DW-1:0] rdata;
        logic [24:0] tbl;
        logic eop;
        logic deep;
        logic soe;
        logic [1:0] pri_svc;
        logic [1:0] pri_psv;
        logic [1:0] pri_tick;
        logic [2:0] sync;
        logic ext_lvl;
        logic [IRQ_N-1:0] pend_prev;
        logic latch;
        logic wake;
        logic sleep_now;
        logic reset_req;
        logic fault;
    } scb_state_s;

    scb_state_s s_q;
    scb_state_s s_d;

    logic [IRQ_N-1:0] pend_new;
    logic ext_rise;
    logic evt;
    logic full_word;
    logic [SCB_DW-1:0] rd_word;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // unaligned addresses never hit a register; partial byteenable is checked only on writes
    function automatic logic scb_hit(input logic [SCB_AW-1:0] a, input logic [SCB_AW-1:0] ofs);
        scb_hit = (a == ofs);
    endfunction : scb_hit

    // ------------------------------------------------------------
    // read multiplexer
    // ------------------------------------------------------------
    always_comb begin
        rd_word = '0;
        if (scb_hit(bus_req.address, SCB_OFS_TABLE)) begin
            rd_word[31:SCB_TBL_LSB] = s_q.tbl;
        end else if (scb_hit(bus_req.address, SCB_OFS_RESET_CTL)) begin
            // key, byte order, reset request and debug bits all read zero
            rd_word[31:SCB_KEY_LSB] = 16'h0000;
            rd_word[SCB_BYTE_ORDER_BIT] = 1'b0;
            rd_word[SCB_RESET_REQ_BIT] = 1'b0;
            rd_word[SCB_DBG_CLR_BIT] = 1'b0;
        end else if (scb_hit(bus_req.address, SCB_OFS_SLEEP)) begin
            rd_word[SCB_EOP_BIT] = s_q.eop;
            rd_word[SCB_DEEP_BIT] = s_q.deep;
            rd_word[SCB_SOE_BIT] = s_q.soe;
        end else if (scb_hit(bus_req.address, SCB_OFS_CONFIG)) begin
            rd_word[SCB_STACK8_BIT] = 1'b1;
            rd_word[SCB_TRAP_BIT] = 1'b1;
        end else if (scb_hit(bus_req.address, SCB_OFS_PRI2)) begin
            rd_word[SCB_PRI_SVC_MSB -: 2] = s_q.pri_svc;
        end else if (scb_hit(bus_req.address, SCB_OFS_PRI3)) begin
            rd_word[SCB_PRI_TICK_MSB -: 2] = s_q.pri_tick;
            rd_word[SCB_PRI_PSV_MSB -: 2] = s_q.pri_psv;
        end else begin
            rd_word = '0;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        full_word = (bus_req.byteenable == 4'hF);
        s_d.rsp_wait = 1'b1;
        s_d.reset_req = 1'b0;
        s_d.wake = 1'b0;
        s_d.sleep_now = 1'b0;

        // bus slave: one wait cycle, write lands on the edge that sees waitrequest low
        case (s_q.bus_st)
            SCB_IDLE: begin
                if (bus_req.read || bus_req.write) begin
                    s_d.bus_st = SCB_ACK;
                    s_d.rsp_wait = 1'b0;
                    if (bus_req.read) begin
                        s_d.rdata = rd_word;
                    end
                end
            end
            SCB_ACK: begin
                s_d.bus_st = SCB_IDLE;
                if (bus_req.write && full_word) begin
                    if (scb_hit(bus_req.address, SCB_OFS_TABLE)) begin
                        s_d.tbl = bus_req.writedata[31:SCB_TBL_LSB];
                    end else if (scb_hit(bus_req.address, SCB_OFS_RESET_CTL)) begin
                        // wrong key drops the whole word; debug clear bit has no effect
                        if (bus_req.writedata[31:SCB_KEY_LSB] == SCB_WRITE_KEY) begin
                            s_d.reset_req = bus_req.writedata[SCB_RESET_REQ_BIT];
                        end
                    end else if (scb_hit(bus_req.address, SCB_OFS_SLEEP)) begin
                        // bits 3 and 0 are not stored, whatever software writes
                        s_d.eop = bus_req.writedata[SCB_EOP_BIT];
                        s_d.deep = bus_req.writedata[SCB_DEEP_BIT];
                        s_d.soe = bus_req.writedata[SCB_SOE_BIT];
                    end else if (scb_hit(bus_req.address, SCB_OFS_PRI2)) begin
                        s_d.pri_svc = bus_req.writedata[SCB_PRI_SVC_MSB -: 2];
                    end else if (scb_hit(bus_req.address, SCB_OFS_PRI3)) begin
                        s_d.pri_tick = bus_req.writedata[SCB_PRI_TICK_MSB -: 2];
                        s_d.pri_psv = bus_req.writedata[SCB_PRI_PSV_MSB -: 2];
                    end else begin
                        s_d.bus_st = SCB_IDLE;
                    end
                end
            end
            default: begin
                s_d.bus_st = SCB_IDLE;
            end
        endcase

        // external event: three stages, a change counts once stages two and three agree
        s_d.sync = {s_q.sync[1:0], ext_event};
        if (s_q.sync[2] == s_q.sync[1]) begin
            s_d.ext_lvl = s_q.sync[2];
        end
        ext_rise = (s_q.sync[2] == s_q.sync[1]) && s_q.sync[2] && !s_q.ext_lvl;

        // only a fresh pending edge counts, not a pending level
        pend_new = irq_pending & ~s_q.pend_prev & (irq_enable | {IRQ_N{s_q.eop}});
        s_d.pend_prev = irq_pending;
        evt = (|pend_new) || send_event_instr || ext_rise;

        // a waiting core consumes the event; otherwise it is held for the next wait
        if (core_in_wait_for_event && (evt || s_q.latch)) begin
            s_d.wake = 1'b1;
            s_d.latch = 1'b0;
        end else if (evt) begin
            s_d.latch = 1'b1;
        end

        if (handler_to_thread && s_q.soe) begin
            s_d.sleep_now = 1'b1;
        end
        s_d.fault = misaligned_access;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.bus_st <= SCB_IDLE;
            s_q.rsp_wait <= 1'b1;
            s_q.tbl <= SCB_TBL_RST;
            s_q.eop <= SCB_CTL_RST;
            s_q.deep <= SCB_CTL_RST;
            s_q.soe <= SCB_CTL_RST;
            s_q.pri_svc <= SCB_PRI_RST;
            s_q.pri_psv <= SCB_PRI_RST;
            s_q.pri_tick <= SCB_PRI_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus_rsp.readdata = s_q.rdata;
    assign bus_rsp.waitrequest = s_q.rsp_wait;
    assign wake_core = s_q.wake;
    assign sleep_enter = s_q.sleep_now;
    assign deep_sleep_select = s_q.deep;
    assign system_reset_request = s_q.reset_req;
    assign hard_fault_exception = s_q.fault;
    assign table_base_field = s_q.tbl;
    assign supervisor_call_priority = s_q.pri_svc;
    assign pendable_service_priority = s_q.pri_psv;
    assign tick_priority = s_q.pri_tick;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    logic ack_wr;
    assign ack_wr = (s_q.bus_st == SCB_ACK) && bus_req.write && full_word;

    property p_tbl_write;
        @(posedge core_clk) disable iff (rst)
        ack_wr && scb_hit(bus_req.address, SCB_OFS_TABLE)
        |=> table_base_field == $past(bus_req.writedata[31:SCB_TBL_LSB]);
    endproperty
    a_tbl_write: assert property (p_tbl_write) else $error("table base not stored");

    property p_key_reject;
        @(posedge core_clk) disable iff (rst)
        ack_wr && scb_hit(bus_req.address, SCB_OFS_RESET_CTL)
        && (bus_req.writedata[31:SCB_KEY_LSB] != SCB_WRITE_KEY)
        |=> !system_reset_request;
    endproperty
    a_key_reject: assert property (p_key_reject) else $error("unkeyed write acted");

    property p_reset_pulse;
        @(posedge core_clk) disable iff (rst)
        ack_wr && scb_hit(bus_req.address, SCB_OFS_RESET_CTL)
        && (bus_req.writedata[31:SCB_KEY_LSB] == SCB_WRITE_KEY) && bus_req.writedata[SCB_RESET_REQ_BIT]
        |=> system_reset_request ##1 !system_reset_request;
    endproperty
    a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse wrong");

    property p_ctl_read;
        @(posedge core_clk) disable iff (rst)
        (s_q.bus_st == SCB_IDLE) && bus_req.read && scb_hit(bus_req.address, SCB_OFS_RESET_CTL)
        |=> !bus_rsp.waitrequest && (bus_rsp.readdata == 32'h00000000);
    endproperty
    a_ctl_read: assert property (p_ctl_read) else $error("reset control read nonzero");

    property p_cfg_read;
        @(posedge core_clk) disable iff (rst)
        (s_q.bus_st == SCB_IDLE) && bus_req.read && scb_hit(bus_req.address, SCB_OFS_CONFIG)
        |=> bus_rsp.readdata == 32'h00000208;
    endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("config flags wrong");

    property p_pri_read;
        @(posedge core_clk) disable iff (rst)
        (s_q.bus_st == SCB_IDLE) && bus_req.read && scb_hit(bus_req.address, SCB_OFS_PRI3)
        |=> (bus_rsp.readdata[29:24] == 6'h00) && (bus_rsp.readdata[21:0] == 22'h000000)
        && ({bus_rsp.readdata[31:30], 6'h00} <= SCB_PRI_MAX);
    endproperty
    a_pri_read: assert property (p_pri_read) else $error("priority low bits set");

    property p_wait_one;
        @(posedge core_clk) disable iff (rst)
        !bus_rsp.waitrequest |=> bus_rsp.waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest low twice");

    property p_event_latched;
        @(posedge core_clk) disable iff (rst)
        (s_q.latch && !core_in_wait_for_event) ##1 core_in_wait_for_event |=> wake_core;
    endproperty
    a_event_latched: assert property (p_event_latched) else $error("latched event lost");

    property p_disabled_quiet;
        @(posedge core_clk) disable iff (rst)
        core_in_wait_for_event && !s_q.latch && !s_q.eop && !send_event_instr && !ext_rise
        && ((irq_pending & ~s_q.pend_prev & irq_enable) == '0)
        |=> !wake_core;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled interrupt woke core");

    property p_ext_wake;
        @(posedge core_clk) disable iff (rst)
        ext_rise && core_in_wait_for_event |=> wake_core;
    endproperty
    a_ext_wake: assert property (p_ext_wake) else $error("external event missed");

    property p_sleep_exit;
        @(posedge core_clk) disable iff (rst)
        handler_to_thread |=> sleep_enter == $past(s_q.soe);
    endproperty
    a_sleep_exit: assert property (p_sleep_exit) else $error("sleep on return wrong");

    property p_fault;
        @(posedge core_clk) disable iff (rst)
        misaligned_access |=> hard_fault_exception;
    endproperty
    a_fault: assert property (p_fault) else $error("no hard fault");

endmodule : scb_regs

`default_nettype wire

// ### scb_core_model.sv
// far-side model: core, interrupt controller and event sources
`default_nettype none

module scb_core_model
    import scb_pkg::*;
(
    input wire logic core_clk,
    output logic [31:0] irq_pending,
    output logic [31:0] irq_enable,
    output logic send_event_instr,
    output logic ext_event,
    output logic core_in_wait_for_event,
    output logic handler_to_thread,
    output logic misaligned_access
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        irq_pending = 32'h0;
        irq_enable = 32'h0;
        {misaligned_access, handler_to_thread, send_event_instr} = 3'h0;
        ext_event = 1'h0;
        core_in_wait_for_event = 1'h0;
    end

    // ------------------------------------------------------------
    // stimulus tasks
    // ------------------------------------------------------------
    // k: 0 send event, 1 handler return, 2 misaligned access
    task automatic pulse(input int k);
        @(posedge core_clk);
        {misaligned_access, handler_to_thread, send_event_instr} <= 3'h1 << k;
        @(posedge core_clk);
        {misaligned_access, handler_to_thread, send_event_instr} <= 3'h0;
    endtask : pulse

    // pin held several cycles so the input filter agrees
    task automatic ext_rise;
        @(posedge core_clk);
        ext_event <= 1'h1;
        repeat (4) @(posedge core_clk);
        ext_event <= 1'h0;
    endtask : ext_rise

    task automatic set_irq(input logic [31:0] p, input logic [31:0] e);
        @(posedge core_clk);
        irq_pending <= p;
        irq_enable <= e;
    endtask : set_irq

    task automatic set_wait(input logic w);
        @(posedge core_clk);
        core_in_wait_for_event <= w;
    endtask : set_wait

endmodule : scb_core_model

`default_nettype wire

// ### testbench.sv
// self-checking bench for the system control register bank
`default_nettype none

module testbench
    import scb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk, rst;
    scb_bus_req_s bus_req;
    scb_bus_rsp_s bus_rsp;
    logic [3:0] be = 4'hF;
    logic [31:0] irq_pending, irq_enable, rd;
    logic send_event_instr, ext_event, core_in_wait_for_event, handler_to_thread, misaligned_access;
    logic wake_core, sleep_enter, deep_sleep_select, system_reset_request, hard_fault_exception;
    logic [24:0] table_base_field;
    logic [1:0] supervisor_call_priority, pendable_service_priority, tick_priority;
    int mismatches = 0, checks = 0, cycles = 0;
    int n_wake = 0, n_sleep = 0, n_rst = 0, n_fault = 0;

    scb_regs #(.IRQ_N(32)) u_dut (.core_clk, .rst, .bus_req, .bus_rsp, .irq_pending, .irq_enable,
        .send_event_instr, .ext_event, .core_in_wait_for_event, .handler_to_thread, .misaligned_access,
        .wake_core, .sleep_enter, .deep_sleep_select, .system_reset_request, .hard_fault_exception,
        .table_base_field, .supervisor_call_priority, .pendable_service_priority, .tick_priority);

    scb_core_model u_core (.core_clk, .irq_pending, .irq_enable, .send_event_instr, .ext_event,
        .core_in_wait_for_event, .handler_to_thread, .misaligned_access);

    initial begin
        core_clk = 1'h0;
        forever #20 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // mid-cycle sampling avoids racing the design's own edge
    // ------------------------------------------------------------
    always @(negedge core_clk) begin
        n_wake <= n_wake + int'(wake_core === 1'h1);
        n_sleep <= n_sleep + int'(sleep_enter === 1'h1);
        n_rst <= n_rst + int'(system_reset_request === 1'h1);
        n_fault <= n_fault + int'(hard_fault_exception === 1'h1);
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", s, exp, seen);
        end
    endtask : chk

    // byte enables taken from be, held until waitrequest is seen low
    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus_req <= '{read: !w, write: w, address: a, writedata: d, byteenable: be};
        do @(posedge core_clk); while (bus_rsp.waitrequest !== 1'h0);
        rd = bus_rsp.readdata;
        bus_req.read <= 1'h0;
        bus_req.write <= 1'h0;
    endtask : xfer

    task automatic rdc(input logic [5:0] a, input logic [31:0] exp, input string s);
        xfer(1'h0, a, 32'h0);
        chk(s, rd, exp);
    endtask : rdc

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'h1;
        bus_req = '0;
        cyc(10);
        rst <= 1'h0;
        rdc(SCB_OFS_TABLE, 32'h0, "table");
        rdc(SCB_OFS_RESET_CTL, 32'h0, "reset_ctl");
        rdc(SCB_OFS_SLEEP, 32'h0, "sleep");
        rdc(SCB_OFS_CONFIG, 32'h208, "config");
        rdc(SCB_OFS_PRI2, 32'h0, "pri2");
        rdc(SCB_OFS_PRI3, 32'h0, "pri3");
        rdc(6'h04, 32'h0, "unmapped");
        xfer(1'h1, SCB_OFS_CONFIG, 32'h0);
        rdc(SCB_OFS_CONFIG, 32'h208, "config_ro");
        xfer(1'h1, SCB_OFS_TABLE, 32'hFFFFFFFF);
        rdc(SCB_OFS_TABLE, 32'hFFFFFF80, "table_all");
        chk("table_base_field", {7'h0, table_base_field}, 32'h01FFFFFF);
        // partial-byte write must leave the stored word alone
        be = 4'h3;
        xfer(1'h1, SCB_OFS_TABLE, 32'h0);
        be = 4'hF;
        rdc(SCB_OFS_TABLE, 32'hFFFFFF80, "table_partial");
        xfer(1'h1, SCB_OFS_PRI2, 32'hFFFFFFFF);
        rdc(SCB_OFS_PRI2, 32'hC0000000, "pri2_all");
        xfer(1'h1, SCB_OFS_PRI3, 32'hFFFFFFFF);
        rdc(SCB_OFS_PRI3, 32'hC0C00000, "pri3_all");
        chk("pri_out", {26'h0, supervisor_call_priority, pendable_service_priority, tick_priority}, 32'h3F);
        xfer(1'h1, SCB_OFS_PRI3, 32'h40800000);
        rdc(SCB_OFS_PRI3, 32'h40800000, "pri3_mid");
        chk("pri3_out", {28'h0, tick_priority, pendable_service_priority}, 32'h6);
        // key mismatch first: the request bit must not leak through
        xfer(1'h1, SCB_OFS_RESET_CTL, 32'h12340004);
        cyc(2);
        chk("bad_key", n_rst, 32'h0);
        xfer(1'h1, SCB_OFS_RESET_CTL, 32'h05FA0000);
        cyc(2);
        chk("key_zero", n_rst, 32'h0);
        xfer(1'h1, SCB_OFS_RESET_CTL, 32'h05FA0004);
        cyc(2);
        chk("reset_pulse", n_rst, 32'h1);
        rdc(SCB_OFS_RESET_CTL, 32'h0, "reset_ctl_rd");
        xfer(1'h1, SCB_OFS_SLEEP, 32'h4);
        cyc(1);
        chk("deep_on", deep_sleep_select, 32'h1);
        u_core.pulse(1);
        cyc(2);
        chk("no_sleep", n_sleep, 32'h0);
        xfer(1'h1, SCB_OFS_SLEEP, 32'h2);
        cyc(1);
        chk("deep_off", deep_sleep_select, 32'h0);
        u_core.pulse(1);
        cyc(2);
        chk("sleep", n_sleep, 32'h1);
        rdc(SCB_OFS_SLEEP, 32'h2, "sleep_rd");
        xfer(1'h1, SCB_OFS_SLEEP, 32'h0);
        u_core.set_wait(1'h1);
        u_core.set_irq(32'h1, 32'h0);
        cyc(6);
        chk("disabled_irq", n_wake, 32'h0);
        u_core.set_irq(32'h3, 32'h2);
        cyc(6);
        chk("enabled_irq", n_wake, 32'h1);
        u_core.set_irq(32'h0, 32'h2);
        u_core.set_wait(1'h0);
        u_core.pulse(0);
        cyc(6);
        chk("latched", n_wake, 32'h1);
        u_core.set_wait(1'h1);
        cyc(6);
        chk("latch_wake", n_wake, 32'h2);
        u_core.ext_rise();
        cyc(8);
        chk("ext_wake", n_wake, 32'h3);
        xfer(1'h1, SCB_OFS_SLEEP, 32'h10);
        rdc(SCB_OFS_SLEEP, 32'h10, "eop_rd");
        u_core.set_irq(32'h4, 32'h2);
        cyc(6);
        chk("any_irq", n_wake, 32'h4);
        u_core.pulse(2);
        cyc(2);
        chk("hard_fault", n_fault, 32'h1);
        // second reset in mid-run: stored fields must fall back to zero
        rst <= 1'h1;
        cyc(2);
        rst <= 1'h0;
        rdc(SCB_OFS_TABLE, 32'h0, "table_rst");
        rdc(SCB_OFS_SLEEP, 32'h0, "sleep_rst");
        rdc(SCB_OFS_PRI3, 32'h0, "pri3_rst");
        end_sim();
    end

endmodule : testbench

`default_nettype wire
